// >>> hw/hdr_params.svh
// Purpose: constants for the address-phase header block
// Assumes: 64-bit multiplexed address/data bus, 200 MHz clock
// Notes:   offsets are byte addresses on the register bus
`ifndef HDR_PARAMS_SVH
`define HDR_PARAMS_SVH

// header field positions
`define ADDR_LSB      0
`define ADDR_MSB      35
`define TYPE_LSB      36
`define TYPE_MSB      39
`define SIZE_LSB      40
`define SIZE_MSB      42
`define CACHE_BIT     43
`define LOCK_BIT      44
`define BOOT_BIT      45
`define VIDX_LSB      46
`define VIDX_MSB      53
`define RSV_LSB       54
`define RSV_MSB       58
`define SUP_BIT       59
`define MID_LSB       60
`define MID_MSB       63

// type codes
`define TC_WRITE      4'h0
`define TC_READ       4'h1
`define TC_CINV       4'h2
`define TC_CREAD      4'h3
`define TC_CWINV      4'h4
`define TC_CRINV      4'h5

// size codes
`define SZ_8B         3'h3
`define SZ_32B        3'h5

// register byte offsets
`define REG_CTRL      12'h000
`define REG_STATUS    12'h004
`define REG_ADDR_LO   12'h008
`define REG_ADDR_HI   12'h00C
`define REG_VIDX      12'h010
`define REG_BEAT      12'h014
`define REG_BEAT_LO   12'h018

// reset values
`define CTRL_RST      32'h0000_0000

`endif

// >>> hw/hdr_pkg.sv
// Purpose: types for the address-phase header block
// Assumes: constants live in hdr_params.svh
// Notes:   no constants here, only types
package hdr_pkg;
   // transaction kind after decode
   typedef enum logic [6:0] {
      k_write  = 7'b000_0001,
      k_read   = 7'b000_0010,
      k_cinv   = 7'b000_0100,
      k_cread  = 7'b000_1000,
      k_cwinv  = 7'b001_0000,
      k_crinv  = 7'b010_0000,
      k_rsvd   = 7'b100_0000
   } kind_e;

   // lock tracker states
   typedef enum logic [1:0] {
      lk_free  = 2'b01,
      lk_held  = 2'b10
   } lock_e;
endpackage : hdr_pkg

// >>> hw/wrap_addr.sv
// Purpose: next beat address for wrapping or aligned bursts
// Assumes: combinational, address in 8-byte beats
// Notes:   bits above n stay fixed; wraps modulo burst length
`timescale 1ns/100ps
`include "hdr_params.svh"

module wrap_addr #(
   parameter int AW = 36
) (
   // current beat and size
   input  wire logic [AW-1:0] cur_addr,
   input  wire logic [2:0]    size_code,
   // next beat
   output logic      [AW-1:0] nxt_addr
);
   // mask of bits n:3 per size, empty for 8 bytes or less
   wire logic [3:0] low_mask;
   wire logic [3:0] inc_low;
   assign low_mask = (size_code > `SZ_8B) ?
                     4'((5'h1 << (size_code - 3'h3)) - 5'h1) : 4'h0;
   assign inc_low  = cur_addr[6:3] + 4'h1;
   assign nxt_addr = {cur_addr[AW-1:7],
                      (inc_low & low_mask) | (cur_addr[6:3] & ~low_mask),
                      3'h0};
endmodule : wrap_addr

// >>> hw/hdr_unit.sv
// Purpose: decode an address-phase header, track lock, form beats
// Assumes: bus pins sampled through two flops; AXI4-Lite registers
// Notes:   slave/snooper side; master fields are only observed
`timescale 1ns/100ps
`include "hdr_params.svh"

module hdr_unit (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // bus pins, raw
   input  wire logic [63:0] muxed_addr_data_bus,
   input  wire logic        address_strobe,
   input  wire logic        bus_busy,
   input  wire logic        data_ready_ack,
   input  wire logic        retry_issued,
   // beat address and status out
   output logic      [35:0] beat_addr,
   output logic             burst_active,
   output logic             locked,
   output logic             hdr_error,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic      [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   // axi4-lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   ////////////////////////////////////////////////////////////////////////
   logic [63:0] bus_s1_r, bus_s2_r;    // bus lines, two stages
   logic [3:0]  ctl_s1_r, ctl_s2_r;    // strobe, busy, ack, retry
   // two flops before any logic reads a pin
   always_ff @(posedge sys_clk) begin
      bus_s1_r <= muxed_addr_data_bus;
      bus_s2_r <= bus_s1_r;
      ctl_s1_r <= {retry_issued, data_ready_ack, bus_busy, address_strobe};
      ctl_s2_r <= ctl_s1_r;
   end
   wire logic strobe_s = ctl_s2_r[0];  // header cycle marker
   wire logic busy_s   = ctl_s2_r[1];  // bus held
   wire logic ack_s    = ctl_s2_r[2];  // beat acknowledged
   wire logic rr_s     = ctl_s2_r[3];  // our retry pending
   logic busy_d_r;                     // busy last cycle
   always_ff @(posedge sys_clk) begin
      if (rst) busy_d_r <= 1'b0;
      else     busy_d_r <= busy_s;
   end

   ////////////////////////////////////////////////////////////////////////
   // header field split
   ////////////////////////////////////////////////////////////////////////
   // address lines
   wire logic [35:0] phys_addr_field = bus_s2_r[`ADDR_MSB:`ADDR_LSB];
   wire logic [3:0]  type_f  = bus_s2_r[`TYPE_MSB:`TYPE_LSB];
   wire logic [2:0]  size_f  = bus_s2_r[`SIZE_MSB:`SIZE_LSB];
   wire logic [7:0]  virt_index_field = bus_s2_r[`VIDX_MSB:`VIDX_LSB];
   wire logic [3:0]  mid_f   = bus_s2_r[`MID_MSB:`MID_LSB];
   wire logic [5:0]  flags_f = {bus_s2_r[`SUP_BIT], bus_s2_r[`BOOT_BIT],
                                bus_s2_r[`LOCK_BIT], bus_s2_r[`CACHE_BIT],
                                bus_s2_r[`RSV_MSB], bus_s2_r[`RSV_LSB]};

   function automatic hdr_pkg::kind_e decode_type(input logic [3:0] t);
      case (t)
         `TC_WRITE: decode_type = hdr_pkg::k_write;
         `TC_READ:  decode_type = hdr_pkg::k_read;
         `TC_CINV:  decode_type = hdr_pkg::k_cinv;
         `TC_CREAD: decode_type = hdr_pkg::k_cread;
         `TC_CWINV: decode_type = hdr_pkg::k_cwinv;
         `TC_CRINV: decode_type = hdr_pkg::k_crinv;
         default:   decode_type = hdr_pkg::k_rsvd;
      endcase
   endfunction : decode_type

   hdr_pkg::kind_e kind_w;
   assign kind_w = decode_type(type_f);
   wire logic coherent_w = (kind_w == hdr_pkg::k_cinv) ||
                           (kind_w == hdr_pkg::k_cread) ||
                           (kind_w == hdr_pkg::k_cwinv) ||
                           (kind_w == hdr_pkg::k_crinv);
   wire logic is_read_w  = (kind_w == hdr_pkg::k_read) ||
                           (kind_w == hdr_pkg::k_cread) ||
                           (kind_w == hdr_pkg::k_crinv);
   // coherent forces 32 bytes; reserved flagged
   wire logic [2:0] eff_size_w = coherent_w ? `SZ_32B : size_f;
   wire logic bad_w = (kind_w == hdr_pkg::k_rsvd) ||
                      (coherent_w && size_f != `SZ_32B);

   ////////////////////////////////////////////////////////////////////////
   // control register fields
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_r;                // software control
   wire logic   aligned_mode = ctrl_r[0];  // snoop-hit aligned order
   wire logic   rr_capable   = ctrl_r[1];  // we may issue retries

   ////////////////////////////////////////////////////////////////////////
   // header capture
   ////////////////////////////////////////////////////////////////////////
   logic [35:0] hdr_addr_r;            // captured address
   logic [3:0]  hdr_type_r;            // captured type
   logic [2:0]  hdr_size_r;            // effective size
   logic [7:0]  hdr_vidx_r;            // virtual index
   logic [3:0]  hdr_mid_r;             // requester module number
   logic [3:0]  rr_mid_r;              // module to reconnect to
   logic [5:0]  hdr_flags_r;           // advisory and reserved bits
   logic        hdr_read_r;            // transaction is a read
   logic [4:0]  beats_left_r;          // beats still to move
   logic [35:0] beat_nxt;              // next beat address
   logic [35:0] first_beat;            // first beat address
   logic [35:0] aligned_base;          // burst-aligned start

   // first write or aligned-read beat; low bits ignored
   wire logic [3:0] low_keep = (eff_size_w > `SZ_8B) ?
        4'((5'h1 << (eff_size_w - 3'h3)) - 5'h1) : 4'h0;
   assign aligned_base = {phys_addr_field[35:7],
                          phys_addr_field[6:3] & ~low_keep, 3'h0};
   // wrapped reads accepted; writes start aligned
   assign first_beat = (is_read_w && !aligned_mode) ?
                       {phys_addr_field[35:3], 3'h0} : aligned_base;

   // beat count: one per 8 bytes
   wire logic [4:0] beat_cnt_w = (eff_size_w > `SZ_8B) ?
        5'(5'h1 << (eff_size_w - 3'h3)) : 5'h1;

   wrap_addr #(.AW(36)) u_wrap (
      .cur_addr  (beat_addr),
      .size_code (hdr_size_r),
      .nxt_addr  (beat_nxt)
   );

   // header taken on strobe; beats advance on each ack
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hdr_addr_r   <= 36'h0_0000_0000;
         hdr_type_r   <= 4'h0;
         hdr_size_r   <= 3'h0;
         hdr_vidx_r   <= 8'h00;
         hdr_mid_r    <= 4'h0;
         hdr_flags_r  <= 6'h00;
         hdr_read_r   <= 1'b0;
         beat_addr    <= 36'h0_0000_0000;
         beats_left_r <= 5'h00;
         burst_active <= 1'b0;
         hdr_error    <= 1'b0;
      end else if (strobe_s) begin
         hdr_addr_r   <= phys_addr_field;
         hdr_type_r   <= type_f;
         hdr_size_r   <= eff_size_w;
         hdr_vidx_r   <= virt_index_field;
         hdr_mid_r    <= mid_f;
         hdr_flags_r  <= flags_f;
         hdr_read_r   <= is_read_w;
         beat_addr    <= first_beat;
         beats_left_r <= beat_cnt_w;
         burst_active <= !bad_w;
         hdr_error    <= bad_w;
      end else if (burst_active && ack_s) begin
         // aligned order uses the same wrap and returns to the block start on the last ack
         beat_addr    <= beat_nxt;
         beats_left_r <= beats_left_r - 5'h01;
         burst_active <= (beats_left_r != 5'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // retry reconnect and lock tracking
   ////////////////////////////////////////////////////////////////////////
   hdr_pkg::lock_e lock_r, lock_nxt;
   wire logic busy_fall = busy_d_r && !busy_s;
   // stays locked across retry-caused busy drops
   always_comb begin
      case (lock_r)
         hdr_pkg::lk_free:
            lock_nxt = (strobe_s && bus_s2_r[`LOCK_BIT]) ?
                       hdr_pkg::lk_held : hdr_pkg::lk_free;
         hdr_pkg::lk_held:
            lock_nxt = (busy_fall && !rr_s) ?
                       hdr_pkg::lk_free : hdr_pkg::lk_held;
         default: lock_nxt = hdr_pkg::lk_free;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lock_r   <= hdr_pkg::lk_free;
         locked   <= 1'b0;
         rr_mid_r <= 4'h0;
      end else begin
         lock_r   <= lock_nxt;
         locked   <= (lock_nxt == hdr_pkg::lk_held);
         if (strobe_s && rr_capable)
            rr_mid_r <= mid_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   ////////////////////////////////////////////////////////////////////////
   logic        aw_held_r, w_held_r;   // channel taken, waiting pair
   logic [11:0] aw_addr_r;             // held write address
   logic [31:0] w_data_r;              // held write data
   logic [3:0]  w_strb_r;              // held strobes
   wire logic   aw_take = s_axi_awvalid && s_axi_awready;
   wire logic   w_take  = s_axi_wvalid && s_axi_wready;
   wire logic   do_wr   = aw_held_r && w_held_r && !s_axi_bvalid;
   wire logic   wr_ok   = (aw_addr_r == `REG_CTRL);
   wire logic   ar_take = s_axi_arvalid && s_axi_arready;

   // write channels, either order
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         aw_addr_r     <= 12'h000;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         ctrl_r        <= `CTRL_RST;
      end else begin
         s_axi_awready <= !aw_held_r && !aw_take;
         s_axi_wready  <= !w_held_r && !w_take;
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            // only control is writable; others answer slverr
            if (wr_ok && w_strb_r[0])
               ctrl_r[1:0] <= w_data_r[1:0];
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read mux of live state
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `REG_CTRL:    rd_val = ctrl_r;
         `REG_STATUS:  rd_val = {7'h00, rr_mid_r, hdr_mid_r, hdr_flags_r,
                                 hdr_read_r, hdr_size_r, hdr_type_r,
                                 hdr_error, locked, burst_active};
         `REG_ADDR_LO: rd_val = hdr_addr_r[31:0];
         `REG_ADDR_HI: rd_val = {28'h000_0000, hdr_addr_r[35:32]};
         `REG_VIDX:    rd_val = {27'h000_0000, beats_left_r[4:0]} |
                                {16'h0000, hdr_vidx_r, 8'h00};
         `REG_BEAT:    rd_val = {28'h000_0000, beat_addr[35:32]};
         `REG_BEAT_LO: rd_val = beat_addr[31:0];
         default: begin
            rd_val = 32'h0000_0000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   // read channel, one outstanding
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : hdr_unit

// >>> sim/hdr_unit_chk.sv
// Purpose: port checks for hdr_unit
// Assumes: bus pins pass two sync flops before use
// Notes:   six-cycle windows cover the sync and capture delay
`timescale 1ns/100ps
module hdr_unit_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // bus pins
   input wire logic        address_strobe,
   input wire logic        bus_busy,
   input wire logic        retry_issued,
   // results
   input wire logic [35:0] beat_addr,
   input wire logic        burst_active,
   input wire logic        locked,
   input wire logic        hdr_error,
   // register bus
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp
);
   logic [3:0] age_r;  // cycles since strobe pin, saturates
   logic [3:0] idle_r; // cycles of busy low without retry
   wire  [3:0] age_nxt = address_strobe ? 4'h0 :
                         (age_r == 4'hF ? 4'hF : age_r + 4'h1);
   wire  [3:0] idle_nxt = (bus_busy || retry_issued) ? 4'h0 :
                          (idle_r == 4'hF ? 4'hF : idle_r + 4'h1);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // reset leaves age saturated so no header looks recent
   always_ff @(posedge sys_clk) begin
      age_r  <= rst ? 4'hF : age_nxt;
      idle_r <= rst ? 4'h0 : idle_nxt;
   end
   beat_low_a:
   assert property (beat_addr[2:0] == 3'h0) else $error("beat low bits set");
   wrap_hold_a:
   assert property ($changed(beat_addr[35:7]) |-> age_r <= 4'h6)
      else $error("upper beat bits moved in burst");
   beat_move_a:
   assert property ($changed(beat_addr) |-> $past(burst_active) || age_r <= 4'h6)
      else $error("beat moved with no burst");
   burst_cause_a:
   assert property ($rose(burst_active) |-> age_r <= 4'h6)
      else $error("burst began with no header");
   err_cause_a:
   assert property ($changed(hdr_error) |-> age_r <= 4'h6)
      else $error("error flag moved with no header");
   lock_cause_a:
   assert property ($rose(locked) |-> age_r <= 4'h6)
      else $error("lock with no header");
   lock_retry_a:
   assert property (locked && retry_issued && $past(retry_issued)
      && $past(retry_issued, 2) && $past(retry_issued, 3) |=> locked)
      else $error("lock lost on retry");
   unlock_a:
   assert property (idle_r == 4'h6 |-> !locked) else $error("lock kept");
   rd_answer_a:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   wr_hold_a:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   cover property ($fell(burst_active));
   cover property ($rose(locked));
   cover property ($rose(hdr_error));
endmodule : hdr_unit_chk
bind hdr_unit hdr_unit_chk chk (.sys_clk, .rst, .address_strobe, .bus_busy,
   .retry_issued, .beat_addr, .burst_active, .locked, .hdr_error,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// >>> sim/hdr_master_model.sv
// Purpose: bus master model sending headers and beat acks
// Assumes: one header at a time; pins change after rising edges
// Notes:   data lines invert after the header and on each ack, so odd acks bring the header back
`timescale 1ns/100ps
`include "hdr_params.svh"
module hdr_master_model (
   // clock
   input  wire logic        sys_clk,
   // bus pins
   output logic      [63:0] muxed_addr_data_bus,
   output logic             address_strobe,
   output logic             bus_busy,
   output logic             data_ready_ack,
   output logic             retry_issued,
   // marks an ack whose beat the bench checks
   output logic             beat_mark
);
   initial begin
      muxed_addr_data_bus = 64'h0f0f_0f0f_0f0f_0f0f;
      {address_strobe, bus_busy, data_ready_ack, retry_issued, beat_mark} = 5'h00;
   end
   ////////////////////////////////////////
   // header image from the transfer description
   function automatic logic [63:0] mk_hdr(input logic [35:0] ad,
      input logic [3:0] typ, input logic [2:0] sz, input logic lk,
      input logic [3:0] mid, input logic [7:0] vx);
      logic coh;
      coh = typ >= `TC_CINV && typ <= `TC_CRINV;
      if (sz > 3'h3 && typ != `TC_READ && typ != `TC_CREAD
         && typ != `TC_CRINV) ad = ad & ~((36'h1 << sz) - 36'h8);
      return {mid, 1'b1, 5'h1f, coh ? vx : 8'hff, 1'b0, lk, 1'b0, sz, typ, ad};
   endfunction : mk_hdr
   // one transfer: busy, header cycle, then one ack per beat
   task automatic issue(input logic [35:0] ad, input logic [3:0] typ,
      input logic [2:0] sz, input logic lk, input logic [3:0] mid,
      input logic [7:0] vx, input int nb, input logic mk, input logic keep);
      @(posedge sys_clk) bus_busy <= 1'b1;
      @(posedge sys_clk) address_strobe <= 1'b1;
      muxed_addr_data_bus <= mk_hdr(ad, typ, sz, lk, mid, vx);
      @(posedge sys_clk) address_strobe <= 1'b0;
      muxed_addr_data_bus <= ~muxed_addr_data_bus;
      repeat (5) @(posedge sys_clk);
      repeat (nb) begin
         data_ready_ack <= 1'b1;
         beat_mark <= mk;
         muxed_addr_data_bus <= ~muxed_addr_data_bus;
         @(posedge sys_clk) data_ready_ack <= 1'b0;
         beat_mark <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      // a locked master keeps the bus
      if (!keep) bus_busy <= 1'b0;
   endtask : issue
   // retry suspends busy for a while
   task automatic retry_gap;
      @(posedge sys_clk) retry_issued <= 1'b1;
      @(posedge sys_clk) bus_busy <= 1'b0;
      repeat (4) @(posedge sys_clk);
      bus_busy <= 1'b1;
      repeat (5) @(posedge sys_clk);
      retry_issued <= 1'b0;
   endtask : retry_gap
   // final busy release ends the locked sequence
   task automatic end_lock;
      @(posedge sys_clk) bus_busy <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask : end_lock
endmodule : hdr_master_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the header decoder
// Assumes: master model on the pins, bench as register master
// Notes:   results pair with notes in arrival order
`timescale 1ns/100ps
`include "hdr_params.svh"
module tb_top;
   logic        sys_clk, rst, beat_mark;           // clock, reset, marker
   logic [63:0] muxed_addr_data_bus;               // model pins
   logic        address_strobe, bus_busy, data_ready_ack, retry_issued;
   logic [35:0] beat_addr;                         // results
   logic        burst_active, locked, hdr_error;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, mid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [63:0] exp_q[$], msk_q[$], e, m;          // notes, oldest first
   logic [31:0] seed_r = 32'h0000_0002;            // xorshift state
   logic        aligned_r;                         // read order setting
   int          failures, checked, cyc;
   hdr_unit dut (.sys_clk, .rst, .muxed_addr_data_bus, .address_strobe,
      .bus_busy, .data_ready_ack, .retry_issued, .beat_addr, .burst_active,
      .locked, .hdr_error, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp);
   hdr_master_model p (.sys_clk, .muxed_addr_data_bus, .address_strobe,
      .bus_busy, .data_ready_ack, .retry_issued, .beat_mark);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed_r = seed_r ^ (seed_r << 13);
      seed_r = seed_r ^ (seed_r >> 17);
      seed_r = seed_r ^ (seed_r << 5);
      return seed_r;
   endfunction : xs
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   // empty queue yields x, a mismatch
   task automatic pop;
      e = exp_q.size() ? exp_q.pop_front() : 'x;
      m = msk_q.size() ? msk_q.pop_front() : '1;
   endtask : pop
   task automatic report_and_stop;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   // register bus master: offer address and data, wait for answer
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
      logic aw_ok = 1'b0, w_ok = 1'b0;
      exp_q.push_back({62'h0, r});
      msk_q.push_back(64'h3);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1 && !aw_ok) s_axi_awvalid <= 1'b0;
         if (s_axi_awready === 1'b1) aw_ok = 1'b1;
         if (s_axi_wready === 1'b1 && !w_ok) s_axi_wvalid <= 1'b0;
         if (s_axi_wready === 1'b1) w_ok = 1'b1;
      end
      repeat (int'(xs() & 32'h3)) @(posedge sys_clk);
      s_axi_bready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, input logic [33:0] x,
      input logic [31:0] k);
      exp_q.push_back({30'h0, x});
      msk_q.push_back({30'h0, 2'b11, k});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      repeat (int'(xs() & 32'h1)) @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // one random transfer, its beat order and its captured fields
   task automatic run(input logic [3:0] typ, input logic [2:0] sz,
      input logic lk, input logic keep, output logic [3:0] md);
      logic [31:0] r;
      logic [35:0] ad, blk;
      logic [7:0]  vx;
      logic        rd, coh, err;
      int          lg, nb, st;
      r = xs();
      md = r[3:0];
      vx = r[11:4];
      ad = {r[15:12], xs()};
      coh = typ >= `TC_CINV && typ <= `TC_CRINV;
      rd = typ == `TC_READ || typ == `TC_CREAD || typ == `TC_CRINV;
      err = typ > `TC_CRINV || (coh && sz != 3'h5);
      lg = coh ? 5 : (sz > 3'h3 ? int'(sz) : 3);
      nb = 1 << (lg - 3);
      if (!rd && sz > 3'h3) ad = ad & ~((36'h1 << lg) - 36'h8);
      blk = ad & ~((36'h1 << lg) - 36'h1);
      st = (rd && !aligned_r) ? int'(ad[6:3]) % nb : 0;
      for (int i = 0; i < nb; i++) begin
         if (typ != `TC_CINV && !err) begin
            exp_q.push_back({28'h0, blk | 36'((st + i) % nb * 8)});
            msk_q.push_back('1);
         end
      end
      p.issue(ad, typ, sz, lk, md, vx, nb, typ != `TC_CINV && !err, keep);
      axi_rd(`REG_STATUS, {13'h0, md, 2'b10, lk, 3'b011, rd,
         coh ? 3'h5 : sz, typ, err, lk, 1'b0}, 32'h001F_FFFF);
      axi_rd(`REG_ADDR_LO, {2'h0, ad[31:0]}, 32'hFFFF_FFFF);
      axi_rd(`REG_VIDX, {18'h0, coh ? vx : 8'hff, 8'h0}, 32'h0000_FF00);
   endtask : run
   // result watcher
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop;
      end
      if (beat_mark === 1'b1) begin
         pop;
         check({28'h0, beat_addr}, e);
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         pop;
         check({30'h0, s_axi_rresp, s_axi_rdata} & m, e & m);
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         pop;
         check({62'h0, s_axi_bresp}, e);
      end
   end
   initial begin
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
      {s_axi_arvalid, s_axi_rready, aligned_r} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'hF;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      axi_rd(`REG_CTRL, 34'h0, 32'hFFFF_FFFF);
      axi_rd(`REG_STATUS, 34'h0, 32'h0000_0007);
      axi_rd(12'h100, {2'b10, 32'h0}, 32'hFFFF_FFFF);
      axi_wr(12'h100, 32'h0000_0003, 2'b10);
      axi_wr(`REG_STATUS, 32'h0000_0003, 2'b10);
      axi_rd(`REG_CTRL, 34'h0, 32'hFFFF_FFFF);
      $display("test registers done");
      for (int s = 0; s < 8; s++) run(`TC_READ, 3'(s), 1'b0, 1'b0, mid);
      run(`TC_WRITE, 3'h6, 1'b0, 1'b0, mid);
      $display("test sizes done");
      axi_wr(`REG_CTRL, 32'h0000_0001, 2'b00);
      aligned_r = 1'b1;
      run(`TC_READ, 3'h7, 1'b0, 1'b0, mid);
      run(`TC_CREAD, 3'h5, 1'b0, 1'b0, mid);
      axi_wr(`REG_CTRL, 32'h0000_0000, 2'b00);
      aligned_r = 1'b0;
      $display("test aligned done");
      for (int t = 2; t < 16; t++)
         run(4'(t), t < 6 ? 3'h5 : 3'h0, 1'b0, 1'b0, mid);
      run(`TC_CREAD, 3'h3, 1'b0, 1'b0, mid);
      $display("test types done");
      axi_wr(`REG_CTRL, 32'h0000_0002, 2'b00);
      run(`TC_READ, 3'h3, 1'b1, 1'b1, mid);
      p.retry_gap;
      axi_rd(`REG_STATUS, {9'h0, mid, 19'h0, 2'b10}, 32'h01E0_0002);
      p.end_lock;
      axi_rd(`REG_STATUS, 34'h0, 32'h0000_0002);
      $display("test lock done");
      report_and_stop;
   end
endmodule : tb_top
